// file: hdl/aotp_regs.v
// Purpose: output mode and test pattern registers of a quad adc, with
//          the serial configuration port and the lane serializers
// Assumes: serial port sclk, cs_n, sdi arrive from outside and are
//          synchronised here; conversion data comes from same-clock logic
// Notes:   frame = r/w bit, 7 address bits, 8 data bits, msb first;
//          sdi sampled on rising sclk, sdo changes on falling sclk;
//          reads return the stored byte, bit 6 of 03h included;
//          a change of width takes effect at the start of the next word, a change of lane count at the next bit
`include "aotp_consts.vh"

module aotp_regs (
  input  wire                                 clk,
  input  wire                                 rst,
  input  wire                                 sclk,
  input  wire                                 cs_n,
  input  wire                                 sdi,
  output reg                                  sdo_q,
  output wire                                 sdo_oe,
  input  wire                                 bit_en,
  input  wire [`AOTP_NCH*`AOTP_SAMP_W-1:0]    conv_data,
  output wire [`AOTP_NCH-1:0]                 lane0,
  output wire [`AOTP_NCH-1:0]                 lane1,
  output wire [`AOTP_NCH-1:0]                 lane1_en,
  output wire [`AOTP_NCH-1:0]                 lane0_en,
  output wire                                 frame
);

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers
  reg [2:0] sclk_s_q;
  reg [1:0] cs_s_q;
  reg [1:0] sdi_s_q;

  // sclk edges are found on the synchronised copy, so a frame needs
  // sclk high and low for at least three clk periods each
  // two flops before use; third sclk stage feeds the edge detector
  always @(posedge clk) begin
    if (rst) begin
      sclk_s_q <= 3'h0;
      cs_s_q   <= 2'h3;
      sdi_s_q  <= 2'h0;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], sclk};
      cs_s_q   <= {cs_s_q[0], cs_n};
      sdi_s_q  <= {sdi_s_q[0], sdi};
    end
  end

  wire sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
  wire sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
  wire sel       = ~cs_s_q[1];

  ////////////////////////////////////////////////////////////////////////
  // register readback decode, used for read data only
  // unmapped addresses read back as zero
  function [7:0] rd_mux;
    input [`AOTP_ADDR_W-1:0] a;
    input [7:0]              m;
    input [7:0]              h;
    input [7:0]              l;
    begin
      case (a)
        `AOTP_ADDR_MODE:  rd_mux = m;
        `AOTP_ADDR_TP_HI: rd_mux = h;
        `AOTP_ADDR_TP_LO: rd_mux = l;
        default:          rd_mux = 8'h00;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // serial configuration port
  reg  [15:0] sh_q;
  reg  [4:0]  cnt_q;
  reg  [7:0]  mode_q;
  reg  [7:0]  tphi_q;
  reg  [7:0]  tplo_q;
  reg  [7:0]  rdsh_q;
  reg         rd_q;

  wire [15:0] sh_d = {sh_q[14:0], sdi_s_q[1]};
  wire [`AOTP_ADDR_W-1:0] addr_d = sh_d[14:8];

  // shift in bits; after the 8th bit latch read data, after 16th write
  always @(posedge clk) begin
    if (rst) begin
      sh_q   <= 16'h0000;
      cnt_q  <= `AOTP_ZERO5;
      rd_q   <= 1'b0;
      rdsh_q <= 8'h00;
      mode_q <= `AOTP_MODE_RST;
      tphi_q <= `AOTP_TPHI_RST;
      tplo_q <= `AOTP_TPLO_RST;
    end else if (!sel) begin
      cnt_q <= `AOTP_ZERO5;
    end else if (sclk_rise && cnt_q != `AOTP_FRAME_BITS) begin
      sh_q  <= sh_d;
      cnt_q <= cnt_q + `AOTP_ONE5;
      if (cnt_q == `AOTP_CNT_ADDR) begin
        rd_q   <= sh_d[7];
        rdsh_q <= rd_mux(sh_d[6:0], mode_q, tphi_q, tplo_q);
      end
      // a write lands only at the 16th bit of a write frame; an
      // unmapped address leaves every register as it was
      if (cnt_q == `AOTP_CNT_LAST && !rd_q) begin
        case (addr_d)
          `AOTP_ADDR_MODE:  mode_q <= sh_d[7:0];
          `AOTP_ADDR_TP_HI: tphi_q <= sh_d[7:0];
          `AOTP_ADDR_TP_LO: tplo_q <= sh_d[7:0];
          default:          mode_q <= mode_q;
        endcase
      end
    // the fall right after the address bits leaves d7 on sdo; only
    // the falls after data bits move the next bit up
    end else if (sclk_fall && rd_q && cnt_q > `AOTP_CNT_DATA) begin
      rdsh_q <= {rdsh_q[6:0], 1'b0};
    end
  end

  // read data drives sdo during the data phase of a read frame
  always @(posedge clk) begin
    if (rst) begin
      sdo_q <= 1'b0;
    end else begin
      sdo_q <= rdsh_q[7];
    end
  end

  // enable is combinational so it drops as soon as the select goes away
  assign sdo_oe = sel & rd_q & (cnt_q >= `AOTP_CNT_DATA);

  ////////////////////////////////////////////////////////////////////////
  // mode decode
  wire [2:0] mode_sel = mode_q[`AOTP_MODE_HI:`AOTP_MODE_LO];
  wire       out_dis  = mode_q[`AOTP_OUTDIS_BIT];
  wire       pat_en   = tphi_q[`AOTP_PEN_BIT];
  wire [`AOTP_SAMP_W-1:0] pattern =
    {tphi_q[`AOTP_TPHI_HI:`AOTP_TPHI_LO], tplo_q};

  reg       two_lane;
  reg [4:0] nbits;

  // lane count and serialization width per code; the word is the sample
  // left-justified in 16 bits, so 14 and 12-bit modes simply stop early
  always @* begin
    case (mode_sel)
      `AOTP_M_2L16: begin
        two_lane = 1'b1;
        nbits    = `AOTP_NB16;
      end
      `AOTP_M_2L14: begin
        two_lane = 1'b1;
        nbits    = `AOTP_NB14;
      end
      `AOTP_M_2L12: begin
        two_lane = 1'b1;
        nbits    = `AOTP_NB12;
      end
      `AOTP_M_1L14: begin
        two_lane = 1'b0;
        nbits    = `AOTP_NB14;
      end
      `AOTP_M_1L12: begin
        two_lane = 1'b0;
        nbits    = `AOTP_NB12;
      end
      `AOTP_M_1L16: begin
        two_lane = 1'b0;
        nbits    = `AOTP_NB16;
      end
      // unused codes fall back to two lanes of 16 bits
      default: begin
        two_lane = 1'b1;
        nbits    = `AOTP_NB16;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // per-channel serializers
  wire [`AOTP_NCH-1:0] l0_raw;
  wire [`AOTP_NCH-1:0] l1_raw;
  wire [`AOTP_NCH-1:0] fr_raw;

  genvar g;
  generate
    for (g = 0; g < `AOTP_NCH; g = g + 1) begin : g_ch
      // pattern replaces conversion data on every channel
      wire [`AOTP_SAMP_W-1:0] samp = pat_en ? pattern :
        conv_data[g*`AOTP_SAMP_W +: `AOTP_SAMP_W];
      aotp_serializer u_ser (
        .clk      (clk),
        .rst      (rst),
        .bit_en   (bit_en),
        .two_lane (two_lane),
        .nbits    (nbits),
        .word     ({samp, 2'b00}),
        .lane0_q  (l0_raw[g]),
        .lane1_q  (l1_raw[g]),
        .frame_q  (fr_raw[g])
      );
    end
  endgenerate

  // output disable gates all data outputs
  assign lane0    = out_dis ? {`AOTP_NCH{1'b0}} : l0_raw;
  // lane1 is also held low in one-lane mode so the unused pair stays quiet
  assign lane1    = (out_dis | ~two_lane) ? {`AOTP_NCH{1'b0}} : l1_raw;
  assign lane0_en = {`AOTP_NCH{~out_dis}};
  assign lane1_en = {`AOTP_NCH{~out_dis & two_lane}};
  assign frame    = ~out_dis & fr_raw[0];

endmodule // aotp_regs

// file: hdl/aotp_serializer.v
// Purpose: shifts one 16-bit word out on one or two lanes per channel
// Assumes: bit_en is a one-cycle pulse at the serial bit rate
// Notes:   word is left-justified; low padding bits go out as zero
`include "aotp_consts.vh"

module aotp_serializer (
  input  wire                    clk,
  input  wire                    rst,
  input  wire                    bit_en,
  input  wire                    two_lane,
  input  wire [4:0]              nbits,
  input  wire [`AOTP_SER_W-1:0]  word,
  output reg                     lane0_q,
  output reg                     lane1_q,
  output reg                     frame_q
);

  reg [`AOTP_SER_W-1:0] shift_q;
  reg [4:0]             left_q;

  // load a new word when the previous one is done, else shift out
  always @(posedge clk) begin
    if (rst) begin
      shift_q <= {`AOTP_SER_W{1'b0}};
      left_q  <= `AOTP_ZERO5;
      lane0_q <= 1'b0;
      lane1_q <= 1'b0;
      frame_q <= 1'b0;
    end else if (bit_en) begin
      if (left_q == `AOTP_ZERO5) begin
        frame_q <= 1'b1;           // marks first bit time of a word
        lane1_q <= word[`AOTP_SER_W-1];
        if (two_lane) begin
          lane0_q <= word[`AOTP_SER_W-2];
          shift_q <= {word[`AOTP_SER_W-3:0], 2'b00};
          left_q  <= nbits - `AOTP_TWO5;
        end else begin
          lane0_q <= word[`AOTP_SER_W-1];
          shift_q <= {word[`AOTP_SER_W-2:0], 1'b0};
          left_q  <= nbits - `AOTP_ONE5;
        end
      end else begin
        frame_q <= 1'b0;
        lane1_q <= shift_q[`AOTP_SER_W-1];
        if (two_lane) begin
          lane0_q <= shift_q[`AOTP_SER_W-2];
          shift_q <= {shift_q[`AOTP_SER_W-3:0], 2'b00};
          left_q  <= left_q - `AOTP_TWO5;
        end else begin
          lane0_q <= shift_q[`AOTP_SER_W-1];
          shift_q <= {shift_q[`AOTP_SER_W-2:0], 1'b0};
          left_q  <= left_q - `AOTP_ONE5;
        end
      end
    end
  end

endmodule // aotp_serializer

// file: inc/aotp_consts.vh
// Purpose: constants for the output mode and test pattern register bank
// Assumes: 8-bit registers reached over the serial configuration port
// Notes:   serial port is mode 0, msb first, 16-bit frames
`ifndef AOTP_CONSTS_VH
`define AOTP_CONSTS_VH

// register addresses (7-bit address field)
`define AOTP_ADDR_W        7
`define AOTP_ADDR_MODE     7'h02
`define AOTP_ADDR_TP_HI    7'h03
`define AOTP_ADDR_TP_LO    7'h04

// field positions
`define AOTP_OUTDIS_BIT    3
`define AOTP_MODE_HI       2
`define AOTP_MODE_LO       0
`define AOTP_PEN_BIT       7
`define AOTP_TPHI_HI       5
`define AOTP_TPHI_LO       0

// reset values
`define AOTP_MODE_RST      8'h00
`define AOTP_TPHI_RST      8'h00
`define AOTP_TPLO_RST      8'h00

// lane/serialization codes
`define AOTP_M_2L16        3'h0
`define AOTP_M_2L14        3'h1
`define AOTP_M_2L12        3'h2
`define AOTP_M_1L14        3'h5
`define AOTP_M_1L12        3'h6
`define AOTP_M_1L16        3'h7

// widths and counts
`define AOTP_SAMP_W        14
`define AOTP_SER_W         16
`define AOTP_CNT_W         5
`define AOTP_FRAME_BITS    5'h10
`define AOTP_NCH           4
`define AOTP_NB16          5'h10
`define AOTP_NB14          5'h0e
`define AOTP_NB12          5'h0c
`define AOTP_ONE5          5'h01
`define AOTP_TWO5          5'h02
`define AOTP_ZERO5         5'h00

// serial frame bit counts
`define AOTP_CNT_ADDR      5'h07
`define AOTP_CNT_DATA      5'h08
`define AOTP_CNT_LAST      5'h0f

`endif

// file: test/aotp_host.sv
// Purpose: serial configuration host for the register bank
// Assumes: 16-bit frames, msb first, sclk idles low, 320 ns period
// Notes:   sdi is inverted between frames so no stale bit lingers
module aotp_host (
  input  wire  clk,
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input  wire  sdo_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle lines
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end
  // one frame: sdi set on low phase, sdo sampled before each of the last 8 rises
  task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clk) cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi <= w[i];
      repeat (5) @(posedge clk);
      if (i < 8) rd = {rd[6:0], sdo_q};
      sclk <= 1'b1;
      repeat (3) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (5) @(posedge clk);
    cs_n <= 1'b1;
    sdi  <= ~sdi;
  endtask
endmodule // aotp_host

// file: test/aotp_regs_sva.sv
// Purpose: port-level checks of the output mode and pattern bank
// Assumes: one clk domain, rst synchronous and active high
// Notes:   attached to every register bank by bind
`include "aotp_consts.vh"
module aotp_regs_sva (
  input wire                 clk,
  input wire                 rst,
  input wire                 cs_n,
  input wire                 sdo_oe,
  input wire                 bit_en,
  input wire [`AOTP_NCH-1:0] lane0,
  input wire [`AOTP_NCH-1:0] lane1,
  input wire [`AOTP_NCH-1:0] lane0_en,
  input wire [`AOTP_NCH-1:0] lane1_en,
  input wire                 frame
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // enables and lane timing
  chk_en_all_alike: assert property (
    lane0_en == 4'h0 || lane0_en == 4'hf)
    else $error("lane enables differ between channels");
  chk_lane1_needs_lane0: assert property (
    (lane1_en & ~lane0_en) == 4'h0)
    else $error("second lane driven without first");
  chk_lanes_hold: assert property (
    $stable(lane0_en) && $stable(lane1_en) && !bit_en
    ##1 $stable(lane0_en) && $stable(lane1_en)
    |-> $stable(lane0) && $stable(lane1))
    else $error("lane bit changed without a bit strobe");
  // re-enabling the outputs can uncover a held frame bit, so only
  // rises seen with the enables steady must follow a bit strobe
  chk_frame_cause: assert property (
    $rose(frame) && $stable(lane0_en) |-> $past(bit_en))
    else $error("frame rose without a bit strobe");
  chk_frame_one_bit: assert property (
    frame && bit_en |=> !frame)
    else $error("frame held past one bit time");
  chk_sdo_quiet: assert property (
    cs_n [*8] |-> !sdo_oe)
    else $error("sdo driven while deselected");
  chk_rst_enables: assert property (
    $fell(rst) |-> ##[0:2] (lane0_en == 4'hf && lane1_en == 4'hf))
    else $error("lanes not enabled after reset");
  chk_rst_lanes: assert property (
    $fell(rst) |-> lane0 == 4'h0 && lane1 == 4'h0)
    else $error("lanes not low after reset");
endmodule // aotp_regs_sva
bind aotp_regs aotp_regs_sva aotp_regs_sva_i (.clk, .rst, .cs_n, .sdo_oe,
  .bit_en, .lane0, .lane1, .lane0_en, .lane1_en, .frame);

// file: test/tb_adc_output_mode_test_pattern_regs.sv
// Purpose: self-checking bench of the output mode and pattern bank
// Assumes: 25 MHz clk, config host model drives the serial port
// Notes:   lanes are collected from the first framed bit onward
`include "aotp_consts.vh"
module tb_adc_output_mode_test_pattern_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst = 1'b1, bit_en = 1'b0;
  logic [55:0] conv_data = {14'h0abc, 14'h1555, 14'h2222, 14'h1234};
  wire         sclk, cs_n, sdi, sdo_q, sdo_oe, frame;
  wire  [3:0]  lane0, lane1, lane0_en, lane1_en;
  int          miscompares = 0, tests_run = 0;
  logic [7:0]  rd;
  logic [15:0] w;
  aotp_regs aotp_regs_i (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi), .sdo_q(sdo_q), .sdo_oe(sdo_oe), .bit_en(bit_en),
    .conv_data(conv_data), .lane0(lane0), .lane1(lane1),
    .lane1_en(lane1_en), .lane0_en(lane0_en), .frame(frame));
  aotp_host host_i (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo_q(sdo_q));
  // free-running clock
  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_i.xfer({1'b0, a, d}, rd);
  endtask
  task automatic rdb(input logic [6:0] a);
    host_i.xfer({1'b1, a, 8'h00}, rd);
  endtask
  // strobe bits until one whole word has been framed and gathered
  task automatic rx(input int n, input logic two, input logic same,
                    output logic [15:0] q);
    int c;
    c = -1;
    q = 16'h0;
    for (int k = 0; k < 80 && c < n; k++) begin
      @(posedge clk) bit_en <= 1'b1;
      @(posedge clk) bit_en <= 1'b0;
      @(posedge clk);
      #1;
      if (frame === 1'b1 && c < 0) c = 0;
      if (c >= 0) begin
        if (same) chk(lane0, {4{lane0[0]}});
        q = two ? {q[13:0], lane1[0], lane0[0]} : {q[14:0], lane0[0]};
        c += two ? 2 : 1;
      end
    end
    if (c < n) begin
      miscompares++;
      wrap_up();
    end
    q = q << (16 - n);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_map;
    for (int a = 2; a < 6; a++) begin
      rdb(a);
      chk(rd, 8'h00);
    end
    wr(3, 8'hc5);
    rdb(3);
    chk(rd, 8'hc5);
    wr(4, 8'h3a);
    rdb(4);
    chk(rd, 8'h3a);
    wr(2, 8'h0f);
    rdb(2);
    chk(rd, 8'h0f);
    wr(5, 8'hff);
    rdb(5);
    chk(rd, 8'h00);
  endtask
  // pattern in every mode; bit 6 set must not show in the word
  task automatic t_modes;
    int n;
    wr(3, 8'hed);
    wr(4, 8'h3a);
    for (int i = 0; i < 8; i++) begin
      if (i == 3 || i == 4) continue;
      n = (i == 0 || i == 7) ? 16 : (i == 1 || i == 5) ? 14 : 12;
      wr(2, i);
      rx(n, i < 5, 1'b1, w);
      chk(w, 16'hb4e8 & ~(16'hffff >> n));
      chk(lane1_en, (i < 5) ? 4'hf : 4'h0);
      if (i >= 5) chk(lane1, 4'h0);
    end
  endtask
  task automatic t_conv_off;
    wr(3, 8'h6d);
    wr(2, 8'h00);
    rx(16, 1'b1, 1'b0, w);
    chk(w, 16'h48d0);
    wr(2, 8'h08);
    chk(lane0_en, 4'h0);
    chk(lane1_en, 4'h0);
    // first bit pair of the next words holds a one on lane0 of channels 0 and 2
    @(posedge clk) bit_en <= 1'b1;
    @(posedge clk) bit_en <= 1'b0;
    @(posedge clk);
    #1;
    chk(lane0, 4'h0);
    chk(lane1, 4'h0);
    wr(2, 8'h00);
    chk(lane0_en, 4'hf);
    chk(lane1_en, 4'hf);
  endtask
  // reset, then each scenario in turn
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_map();
    t_modes();
    t_conv_off();
    wrap_up();
  end
endmodule // tb_adc_output_mode_test_pattern_regs
